// File: core/ptm_consts.svh
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets on the axi4-lite bus
// ----------------------------------------------------------------
`define PTM_OFF_CTL_LO 8'h00
`define PTM_OFF_CTL_HI 8'h04
`define PTM_OFF_CNT_LO 8'h08
`define PTM_OFF_CNT_HI 8'h0c
`define PTM_OFF_PER_LO 8'h10
`define PTM_OFF_PER_HI 8'h14
`define PTM_OFF_STS 8'h18
`define PTM_OFF_MSK 8'h1c

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define PTM_RUN_BIT 15
`define PTM_IDLE_BIT 13
`define PTM_GATE_BIT 6
`define PTM_PS_HI_BIT 5
`define PTM_PS_LO_BIT 4
`define PTM_JOIN_BIT 3
`define PTM_CS_BIT 1

// implemented bits of each control register
`define PTM_CTL_LO_MASK 16'ha07a
`define PTM_CTL_HI_MASK 16'ha072

// ----------------------------------------------------------------
// status / mask bit positions
// ----------------------------------------------------------------
`define PTM_STS_LO 0
`define PTM_STS_HI 1

// ----------------------------------------------------------------
// reset values and prescaler terminal counts
// ----------------------------------------------------------------
`define PTM_PERIOD_RESET 16'hffff
`define PTM_LAST_DIV1 8'h00
`define PTM_LAST_DIV8 8'h07
`define PTM_LAST_DIV64 8'h3f
`define PTM_LAST_DIV256 8'hff

// axi response codes
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2

`endif

// File: core/ptm_pkg.sv
package ptm_pkg;

    // axi response code
    typedef logic [1:0] ptm_resp_type;

    // state of one prescaler / clock front end
    typedef struct packed {
        logic [7:0] pre;      // prescale counter
        logic half;           // internal clock phase, aclk/2
        logic ext_prev;       // pin level one cycle ago
        logic tick;           // one prescaled clock
        logic gate_fall;      // gate went low while accumulating
    } ptm_tick_state_type;

    // whole state of the timer pair and its bus slave
    typedef struct packed {
        logic [15:0] ctl_lo;
        logic [15:0] ctl_hi;
        logic [15:0] cnt_lo;
        logic [15:0] cnt_hi;
        logic [15:0] per_lo;
        logic [15:0] per_hi;
        logic [1:0] sts;
        logic [1:0] msk;
        logic clr_lo;
        logic clr_hi;
        logic irq;
        logic adc;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        ptm_resp_type bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        ptm_resp_type rresp;
    } ptm_main_state_type;

endpackage

// File: core/ptm_tick_if.sv
`timescale 1ns/1ns
`default_nettype none

// configuration into one clock front end, prescaled events back
interface ptm_tick_if;
    logic run_en;
    logic clr;
    logic cs;
    logic gate_en;
    logic [1:0] prescale;
    logic ext_in;
    logic tick;
    logic gate_fall;

    modport ctl (output run_en, clr, cs, gate_en, prescale, ext_in, input tick, gate_fall);
    modport tck (input run_en, clr, cs, gate_en, prescale, ext_in, output tick, gate_fall);
endinterface

`default_nettype wire

// File: core/ptm_tick.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptm_consts.svh"

module ptm_tick (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // configuration and events
    ptm_tick_if.tck tif
);
    import ptm_pkg::*;

    ptm_tick_state_type q;   // registered state
    ptm_tick_state_type d;   // next state
    logic src;               // one undivided input clock this cycle
    logic gated;             // gated accumulation really active
    logic cnt_ok;            // prescaler may advance
    logic [7:0] last;        // terminal prescale count

    // terminal prescale count for a code
    function automatic logic [7:0] ptm_last(input logic [1:0] sel);
        case (sel)
            2'h0: ptm_last = `PTM_LAST_DIV1;
            2'h1: ptm_last = `PTM_LAST_DIV8;
            2'h2: ptm_last = `PTM_LAST_DIV64;
            default: ptm_last = `PTM_LAST_DIV256;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.gate_fall = 1'b0;
        d.half = ~q.half;
        d.ext_prev = tif.ext_in;
        src = tif.cs ? (tif.ext_in & ~q.ext_prev) : q.half;
        gated = ~tif.cs & tif.gate_en;
        cnt_ok = tif.run_en & src & (~gated | tif.ext_in);
        last = ptm_last(tif.prescale);
        if (!tif.run_en || tif.clr) begin
            d.pre = 8'h00;
        end else if (cnt_ok) begin
            if (q.pre >= last) begin
                d.pre = 8'h00;
                d.tick = 1'b1;
            end else begin
                d.pre = q.pre + 8'h01;
            end
        end
        if (tif.run_en && gated && q.ext_prev && !tif.ext_in) begin
            d.gate_fall = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.tick = q.tick;
    assign tif.gate_fall = q.gate_fall;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stop_hold: assert property (!tif.run_en |=> q.pre == 8'h00 && !q.tick)
        else $error("stopped timer still advancing");
    a_prescale_div: assert property (cnt_ok && !tif.clr && q.pre == last |=> q.tick)
        else $error("prescaler missed its terminal count");
    a_ext_no_gate: assert property (tif.cs |=> !q.gate_fall)
        else $error("gate event with external clock");
    a_clr_pre: assert property (tif.clr |=> q.pre == 8'h00)
        else $error("prescaler not reset by control write");
endmodule // ptm_tick

`default_nettype wire

// File: core/ptm_top.sv
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "ptm_consts.svh"

// Behaviour
// - pairing bit joins two timers into 32
// - joined mode ignores high control register
// - joined uses low clock, high flag
// - high count word upper, low lower
// - period upper from high register
// - joined interrupt on 32-bit period match
// - synchronous timer/counter only, no async
// - run bit starts and stops timer
// - idle-halt bit stops timer in idle
// - gating only with internal clock
// - prescale divides by 1,8,64,256
// - clock source: pin rising or internal
// - control write while running resets prescaler
// - adc trigger from high or joined
module ptm_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output ptm_pkg::ptm_resp_type s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output ptm_pkg::ptm_resp_type s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and device mode
    input wire logic ext_clock_pin_low,
    input wire logic ext_clock_pin,
    input wire logic device_idle,
    // events out
    output logic irq,
    output logic adc_trigger
);
    import ptm_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ptm_main_state_type q;   // registered state
    ptm_main_state_type d;   // next state
    logic join_on;           // pair runs as one 32-bit timer
    logic [31:0] cnt32;      // joined count
    logic [31:0] per32;      // joined period
    logic gated_lo;          // low timer in gated accumulation
    logic gated_hi;          // high timer in gated accumulation
    logic ev_lo;             // low timer event this cycle
    logic ev_hi;             // high or joined event this cycle
    logic wr_go;             // write performed this cycle
    logic [1:0] sts_clr;     // write-one-to-clear request
    logic [31:0] wr_merged;  // held write data, merged by lanes in ptm_merge

    // one clock front end per timer half
    ptm_tick_if tif[2] ();

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // true for every offset the slave answers with okay
    function automatic logic ptm_mapped(input logic [7:0] a);
        ptm_mapped = (a[1:0] == 2'h0) && (a <= `PTM_OFF_MSK);
    endfunction

    // merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [15:0] ptm_merge(input logic [15:0] old,
                                              input logic [31:0] w,
                                              input logic [3:0] s);
        ptm_merge = {s[1] ? w[15:8] : old[15:8], s[0] ? w[7:0] : old[7:0]};
    endfunction

    // read mux; unmapped words read zero
    function automatic logic [31:0] ptm_read(input ptm_main_state_type s,
                                             input logic [7:0] a);
        if (a == `PTM_OFF_CTL_LO) begin
            ptm_read = {16'h0000, s.ctl_lo};
        end else if (a == `PTM_OFF_CTL_HI) begin
            ptm_read = {16'h0000, s.ctl_hi};
        end else if (a == `PTM_OFF_CNT_LO) begin
            ptm_read = {16'h0000, s.cnt_lo};
        end else if (a == `PTM_OFF_CNT_HI) begin
            ptm_read = {16'h0000, s.cnt_hi};
        end else if (a == `PTM_OFF_PER_LO) begin
            ptm_read = {16'h0000, s.per_lo};
        end else if (a == `PTM_OFF_PER_HI) begin
            ptm_read = {16'h0000, s.per_hi};
        end else if (a == `PTM_OFF_STS) begin
            ptm_read = {30'h00000000, s.sts};
        end else if (a == `PTM_OFF_MSK) begin
            ptm_read = {30'h00000000, s.msk};
        end else begin
            ptm_read = 32'h00000000;
        end
    endfunction

    // ----------------------------------------------------------------
    // clock front ends
    // ----------------------------------------------------------------
    // pairing bit selects joined mode
    assign join_on = q.ctl_lo[`PTM_JOIN_BIT];
    assign cnt32 = {q.cnt_hi, q.cnt_lo};
    assign per32 = {q.per_hi, q.per_lo};
    assign gated_lo = ~q.ctl_lo[`PTM_CS_BIT] & q.ctl_lo[`PTM_GATE_BIT];
    assign gated_hi = ~join_on & ~q.ctl_hi[`PTM_CS_BIT] & q.ctl_hi[`PTM_GATE_BIT];

    // low half always follows the low control register
    // idle halt gates run
    assign tif[0].run_en = q.ctl_lo[`PTM_RUN_BIT] &
                           ~(q.ctl_lo[`PTM_IDLE_BIT] & device_idle);
    assign tif[0].clr = q.clr_lo;
    assign tif[0].cs = q.ctl_lo[`PTM_CS_BIT];
    assign tif[0].gate_en = q.ctl_lo[`PTM_GATE_BIT];
    assign tif[0].prescale = q.ctl_lo[`PTM_PS_HI_BIT:`PTM_PS_LO_BIT];
    // joined clock and gate from low pin
    assign tif[0].ext_in = ext_clock_pin_low;

    assign tif[1].run_en = ~join_on & q.ctl_hi[`PTM_RUN_BIT] &
                           ~(q.ctl_hi[`PTM_IDLE_BIT] & device_idle);
    assign tif[1].clr = q.clr_hi;
    assign tif[1].cs = q.ctl_hi[`PTM_CS_BIT];
    assign tif[1].gate_en = q.ctl_hi[`PTM_GATE_BIT];
    assign tif[1].prescale = q.ctl_hi[`PTM_PS_HI_BIT:`PTM_PS_LO_BIT];
    assign tif[1].ext_in = ext_clock_pin;

    // one prescaler per half; pins are already synchronous to aclk
    generate
        for (genvar g = 0; g < 2; g++) begin : g_tick
            ptm_tick u_tick (
                .aclk(aclk),
                .aresetn(aresetn),
                .tif(tif[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state: counters, events, bus slave
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.clr_lo = 1'b0;
        d.clr_hi = 1'b0;
        ev_lo = 1'b0;
        ev_hi = 1'b0;
        sts_clr = 2'h0;
        wr_go = q.aw_held & q.w_held & ~q.bvalid;
        wr_merged = q.wdata;

        // counting; the bus write further down wins over a tick
        if (join_on) begin
            if (tif[0].tick) begin
                if (cnt32 == per32) begin
                    {d.cnt_hi, d.cnt_lo} = 32'h00000000;
                    ev_hi = ~gated_lo;
                end else begin
                    {d.cnt_hi, d.cnt_lo} = cnt32 + 32'h00000001;
                end
            end
            if (tif[0].gate_fall) begin
                ev_hi = 1'b1;
            end
        end else begin
            if (tif[0].tick) begin
                if (q.cnt_lo == q.per_lo) begin
                    d.cnt_lo = 16'h0000;
                    ev_lo = ~gated_lo;
                end else begin
                    d.cnt_lo = q.cnt_lo + 16'h0001;
                end
            end
            if (tif[0].gate_fall) begin
                ev_lo = 1'b1;
            end
            if (tif[1].tick) begin
                if (q.cnt_hi == q.per_hi) begin
                    d.cnt_hi = 16'h0000;
                    ev_hi = ~gated_hi;
                end else begin
                    d.cnt_hi = q.cnt_hi + 16'h0001;
                end
            end
            if (tif[1].gate_fall) begin
                ev_hi = 1'b1;
            end
        end

        d.adc = ev_hi;

        // write data accepted and address accepted, in any order
        if (s_axi_awvalid && q.awready) begin
            d.aw_held = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_held = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end

        // perform a write once both halves are in
        if (wr_go) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = ptm_mapped(q.aw_addr) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
            if (q.aw_addr == `PTM_OFF_CTL_LO) begin
                d.ctl_lo = ptm_merge(q.ctl_lo, wr_merged, q.wstrb) & `PTM_CTL_LO_MASK;
                d.clr_lo = q.ctl_lo[`PTM_RUN_BIT];
            end else if (q.aw_addr == `PTM_OFF_CTL_HI) begin
                d.ctl_hi = ptm_merge(q.ctl_hi, wr_merged, q.wstrb) & `PTM_CTL_HI_MASK;
                d.clr_hi = q.ctl_hi[`PTM_RUN_BIT];
            end else if (q.aw_addr == `PTM_OFF_CNT_LO) begin
                d.cnt_lo = ptm_merge(q.cnt_lo, wr_merged, q.wstrb);
            end else if (q.aw_addr == `PTM_OFF_CNT_HI) begin
                d.cnt_hi = ptm_merge(q.cnt_hi, wr_merged, q.wstrb);
            end else if (q.aw_addr == `PTM_OFF_PER_LO) begin
                d.per_lo = ptm_merge(q.per_lo, wr_merged, q.wstrb);
            end else if (q.aw_addr == `PTM_OFF_PER_HI) begin
                d.per_hi = ptm_merge(q.per_hi, wr_merged, q.wstrb);
            end else if (q.aw_addr == `PTM_OFF_STS) begin
                // write one to clear, low lane only
                sts_clr = q.wstrb[0] ? q.wdata[1:0] : 2'h0;
            end else if (q.aw_addr == `PTM_OFF_MSK) begin
                if (q.wstrb[0]) begin
                    d.msk = q.wdata[1:0];
                end
            end
        end

        // response retires on its handshake
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // a new event beats a clear in the same cycle
        d.sts = (q.sts & ~sts_clr) | {ev_hi, ev_lo};
        d.irq = |(d.sts & d.msk);

        // read channel: one read in flight at a time
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = ptm_read(q, s_axi_araddr);
            d.rresp = ptm_mapped(s_axi_araddr) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // readies registered so every output comes from a flop
        d.awready = ~d.aw_held & ~d.bvalid;
        d.wready = ~d.w_held & ~d.bvalid;
        d.arready = ~d.rvalid;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.per_lo <= `PTM_PERIOD_RESET;
            q.per_hi <= `PTM_PERIOD_RESET;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign irq = q.irq;
    assign adc_trigger = q.adc;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // joined match step, then the wrapped state
    sequence s_join_match;
        join_on && tif[0].tick && cnt32 == per32 && !wr_go;
    endsequence
    sequence s_wrapped;
        {q.cnt_hi, q.cnt_lo} == 32'h00000000;
    endsequence

    a_join_wrap: assert property (s_join_match |=> s_wrapped)
        else $error("joined count did not wrap on match");
    a_join_flag: assert property (s_join_match ##0 !gated_lo |=> q.sts[`PTM_STS_HI])
        else $error("joined match did not set high flag");
    // high front end idle when joined
    a_hi_ignored: assert property (join_on [*2] |-> !tif[1].tick)
        else $error("high timer ticked in joined mode");
    a_join_hold: assert property (join_on && !tif[0].tick && !wr_go |=> $stable(cnt32))
        else $error("joined count moved without a tick");
    a_low_wrap: assert property (!join_on && tif[0].tick && q.cnt_lo == q.per_lo &&
                                 !gated_lo && !wr_go
                                 |=> q.cnt_lo == 16'h0000 && q.sts[`PTM_STS_LO])
        else $error("low timer did not wrap on match");
    a_unimpl_zero: assert property ((q.ctl_lo & ~`PTM_CTL_LO_MASK) == 16'h0000 &&
                                    (q.ctl_hi & ~`PTM_CTL_HI_MASK) == 16'h0000)
        else $error("unimplemented control bit set");
    a_adc_pulse: assert property (1'b1 |=> q.adc == $past(ev_hi))
        else $error("adc trigger out of step with high event");
    a_idle_halt: assert property ((q.ctl_lo[`PTM_IDLE_BIT] && device_idle) [*2]
                                  |-> !tif[0].tick)
        else $error("low timer ticked while halted in idle");
    a_irq_level: assert property (q.irq == |(q.sts & q.msk))
        else $error("interrupt level disagrees with status and mask");
endmodule // ptm_top

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptm_consts.svh"
module testbench;
import ptm_pkg::*;
// ----------------------------------------
// bench signals
// ----------------------------------------
logic aclk, aresetn, awv, wv, brdy, arv, rrdy, awr, wr_, bv, arr, rv;
logic irq, adc, pin_lo, pin_hi, idle;
logic [7:0] awa, ara;
logic [31:0] wd, rd_q;
logic [3:0] ws;
ptm_resp_type br, rr, resp_q;
int fails, checks, cyc;
ptm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_q),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .ext_clock_pin_low(pin_lo),
    .ext_clock_pin(pin_hi), .device_idle(idle), .irq(irq), .adc_trigger(adc));
// ----------------------------------------
// shared tasks
// ----------------------------------------
task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
        fails++;
        $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
endtask
// address and data offered together, each dropped when taken
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; ws <= 4'hf; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
    forever begin
        @(posedge aclk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wr_) wv <= 1'b0;
        if (bv) break;
    end
    resp_q = br;
    brdy <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1;
    forever begin
        @(posedge aclk);
        if (arv && arr) arv <= 1'b0;
        if (rv) break;
    end
    rrdy <= 1'b0;
    chk(n, rd_q, e);
endtask
// bounded wait for the interrupt line
task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge aclk);
    chk("irq", irq, 1);
endtask
task automatic tally_and_finish;
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic s_regs;
    rd(`PTM_OFF_PER_HI, 32'h0000ffff, "per_hi rst");
    wr(`PTM_OFF_CTL_LO, 32'hffff7fff);
    chk("bresp ok", resp_q, `PTM_RESP_OKAY);
    rd(`PTM_OFF_CTL_LO, 32'h0000207a, "ctl_lo");
    wr(`PTM_OFF_CTL_HI, 32'hffff7fff);
    rd(`PTM_OFF_CTL_HI, 32'h00002072, "ctl_hi");
    wr(8'h20, 32'h1);
    chk("unmapped", resp_q, `PTM_RESP_SLVERR);
    rd(8'h20, 32'h0, "unmapped rd");
    chk("rresp", rr, `PTM_RESP_SLVERR);
    wr(`PTM_OFF_CTL_LO, 32'h0);
endtask
// separate low timer, internal clock, match then stop and clear
task automatic s_t16;
    wr(`PTM_OFF_PER_LO, 32'h3);
    wr(`PTM_OFF_MSK, 32'h1);
    wr(`PTM_OFF_CTL_LO, 32'h8000);
    wait_irq(40);
    chk("adc lo", adc, 0);
    wr(`PTM_OFF_CTL_LO, 32'h0);
    rd(`PTM_OFF_STS, 32'h1, "sts16");
    wr(`PTM_OFF_STS, 32'h3);
    rd(`PTM_OFF_STS, 32'h0, "w1c");
    chk("irq low", irq, 0);
endtask
// joined pair: carry into high word, slow high prescale ignored
task automatic s_join;
    wr(`PTM_OFF_CTL_HI, 32'h0030);
    wr(`PTM_OFF_CNT_LO, 32'hfffe);
    wr(`PTM_OFF_CNT_HI, 32'h0);
    wr(`PTM_OFF_PER_LO, 32'h2);
    wr(`PTM_OFF_PER_HI, 32'h1);
    wr(`PTM_OFF_MSK, 32'h2);
    wr(`PTM_OFF_CTL_LO, 32'h8008);
    wait_irq(40);
    chk("adc 32", adc, 1);
    wr(`PTM_OFF_CTL_LO, 32'h0);
    rd(`PTM_OFF_STS, 32'h2, "sts32");
    rd(`PTM_OFF_CNT_HI, 32'h0, "wrap hi");
    wr(`PTM_OFF_STS, 32'h3);
endtask
// external pin clock: nothing counts until the pin rises
task automatic s_ext;
    wr(`PTM_OFF_PER_LO, 32'h1);
    wr(`PTM_OFF_CNT_LO, 32'h0);
    wr(`PTM_OFF_MSK, 32'h1);
    wr(`PTM_OFF_CTL_LO, 32'h8002);
    repeat (20) @(posedge aclk);
    chk("ext idle", irq, 0);
    pin_lo <= 1'b1;
    repeat (3) @(posedge aclk);
    pin_lo <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ext one edge", irq, 0);
    pin_lo <= 1'b1;
    repeat (3) @(posedge aclk);
    pin_lo <= 1'b0;
    wait_irq(10);
endtask
// gated accumulation: count only while the pin is high, flag on its fall
task automatic s_gate;
    wr(`PTM_OFF_CTL_LO, 32'h0);
    wr(`PTM_OFF_PER_LO, 32'hffff);
    wr(`PTM_OFF_CNT_LO, 32'h0);
    wr(`PTM_OFF_STS, 32'h3);
    wr(`PTM_OFF_CTL_LO, 32'h8040);
    repeat (10) @(posedge aclk);
    rd(`PTM_OFF_CNT_LO, 32'h0, "gate low");
    chk("gate irq", irq, 0);
    pin_lo <= 1'b1;
    repeat (10) @(posedge aclk);
    pin_lo <= 1'b0;
    wait_irq(10);
    rd(`PTM_OFF_CNT_LO, 32'h5, "gate count");
endtask
// idle mode: halt bit freezes the low timer; clear, it runs at 1:8
task automatic s_idle;
    wr(`PTM_OFF_CTL_LO, 32'h0);
    wr(`PTM_OFF_STS, 32'h3);
    wr(`PTM_OFF_CNT_LO, 32'h0);
    wr(`PTM_OFF_PER_LO, 32'h3);
    idle <= 1'b1;
    wr(`PTM_OFF_CTL_LO, 32'ha000);
    repeat (30) @(posedge aclk);
    chk("idle halt", irq, 0);
    idle <= 1'b0;
    wait_irq(40);
    wr(`PTM_OFF_CTL_LO, 32'h0);
    wr(`PTM_OFF_STS, 32'h3);
    wr(`PTM_OFF_CNT_LO, 32'h0);
    idle <= 1'b1;
    wr(`PTM_OFF_CTL_LO, 32'h8010);
    repeat (50) @(posedge aclk);
    chk("ps8 early", irq, 0);
    wait_irq(40);
    idle <= 1'b0;
endtask
// separate high timer on its own pin; its event drives the adc trigger
task automatic s_hi;
    wr(`PTM_OFF_CTL_LO, 32'h0);
    wr(`PTM_OFF_STS, 32'h3);
    wr(`PTM_OFF_PER_HI, 32'h0);
    wr(`PTM_OFF_CNT_HI, 32'h0);
    wr(`PTM_OFF_MSK, 32'h2);
    wr(`PTM_OFF_CTL_HI, 32'h8002);
    pin_hi <= 1'b1;
    wait_irq(10);
    chk("adc hi", adc, 1);
    pin_hi <= 1'b0;
    wr(`PTM_OFF_CTL_HI, 32'h0);
    rd(`PTM_OFF_STS, 32'h2, "sts hi");
endtask
// ----------------------------------------
// clock, reset, timeout, sequence
// ----------------------------------------
initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
end
always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
        fails++;
        tally_and_finish;
    end
end
initial begin
    aresetn = 1'b0; awv = 0; wv = 0; brdy = 0; arv = 0; rrdy = 0; awa = 0; ara = 0;
    wd = 0; ws = 0; pin_lo = 0; pin_hi = 0; idle = 0; fails = 0; checks = 0; cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_regs;
    s_t16;
    s_join;
    s_ext;
    s_gate;
    s_idle;
    s_hi;
    tally_and_finish;
end
endmodule // testbench
`default_nettype wire
